//--- dd_cfg.svh
// timing, offset and field constants for the drive interface
`ifndef DD_CFG_SVH
`define DD_CFG_SVH
`define DD_CLK_MHZ       125
`define DD_T_SEEKOFF_NS  12000
`define DD_SEEKOFF_CYC   ((`DD_T_SEEKOFF_NS * `DD_CLK_MHZ) / 1000)
`define DD_T_STEP_US     3
`define DD_STEP_CYC      (`DD_T_STEP_US * `DD_CLK_MHZ)
`define DD_T_T2T_US      3000
`define DD_T2T_CYC       (`DD_T_T2T_US * `DD_CLK_MHZ)
`define DD_T_BUF_US      200
`define DD_BUF_CYC       (`DD_T_BUF_US * `DD_CLK_MHZ)
`define DD_T_IDX_US      1500
`define DD_IDX_CYC       (`DD_T_IDX_US * `DD_CLK_MHZ)
`define DD_T_REV_US      16670
`define DD_REV_CYC       (`DD_T_REV_US * `DD_CLK_MHZ)
`define DD_T_SETTLE_US   500
`define DD_SETTLE_CYC    (`DD_T_SETTLE_US * `DD_CLK_MHZ)
`define DD_T_READY_MS    20000
`define DD_READY_CYC     (64'd`DD_T_READY_MS * 64'd`DD_CLK_MHZ * 64'd1000)
`define DD_MAX_CYL       306
`define DD_OFF_CTRL      8'h00
`define DD_OFF_STAT      8'h04
`define DD_OFF_CYL       8'h08
`define DD_OFF_CAUSE     8'h0C
`define DD_CTRL_RECAL    0
`define DD_CTRL_IMMED    1
`define DD_RESP_OKAY     2'h0
`define DD_RESP_DECERR   2'h3
`endif

//--- dd_drive.sv
// drive-side control and data interface of a fixed disk drive
// Contract
// - record only while write gate asserted
// - two low-active lines binary-code four heads
// - direction high steps out, low in
// - slow steps execute as single track moves
// - fast trains accumulate, drive seeks itself
// - respond and light indicator only when selected
// - one-hot switch bank picks selection line
// - seek complete after heads settle on track
// - seek complete drops: recal, 12us, power
// - track zero output only at outermost track
// - fault inhibits writing, clears by gate/deselect
// - listed write, head, supply conditions raise fault
// - index pulse 1.5 ms every revolution
// - not ready inhibits read, write and seek
// - read flux shows positive over negative line
// - write flux on rising pair, gated only
// - recalibrate at power-up, overrun, write fault
// - write gate ignored during power transitions
`include "dd_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module dd_drive
  import dd_pkg::*;
#(
  parameter int unsigned READY_CYC  = 32'(`DD_READY_CYC),
  parameter int unsigned T2T_CYC    = `DD_T2T_CYC,
  parameter int unsigned BUF_CYC    = `DD_BUF_CYC,
  parameter int unsigned REV_CYC    = `DD_REV_CYC,
  parameter int unsigned IDX_CYC    = `DD_IDX_CYC,
  parameter int unsigned SETTLE_CYC = `DD_SETTLE_CYC,
  parameter int unsigned MAX_CYL    = `DD_MAX_CYL
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire dd_axi_req_t axi_req,
  output var  dd_axi_rsp_t axi_rsp,
  input  wire logic        wr_gate_n,
  input  wire logic        head_sel_bit0_n,
  input  wire logic        head_sel_bit1_n,
  input  wire logic        step_n,
  input  wire logic        step_dir_in_n,
  input  wire logic [3:0]  unit_select_n,
  input  wire logic [3:0]  unit_switch,
  input  wire logic        flux_write_pair_p,
  input  wire logic        flux_write_pair_n,
  input  wire logic        medium_flux,
  input  wire logic        wr_current_sense,
  input  wire logic        head_sel_fault,
  input  wire logic        supply_ok,
  input  wire logic        spindle_ok,
  input  wire logic        trk0_sense,
  output logic             seek_done_n_ff,
  output logic             at_outer_track_n_ff,
  output logic             write_fault_n_ff,
  output logic             index_n_ff,
  output logic             ready_n_ff,
  output logic             flux_read_pair_p_ff,
  output logic             flux_read_pair_n_ff,
  output logic             led_ff,
  output logic [1:0]       head_ff,
  output logic             wr_en_ff,
  output logic             head_flux_ff,
  output logic             act_step_ff,
  output logic             act_out_ff
);
  localparam int unsigned STEP_CYC = `DD_STEP_CYC;
  localparam int unsigned SOFF_CYC = `DD_SEEKOFF_CYC;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  // bus slave state
  logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic        aw_got_ff, w_got_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0]  wstrb_ff;
  logic        ctrl_immed_ff;
  // drive state
  dd_seek_t    state_ff, nxt_state;
  logic [9:0]  cyl_ff, nxt_cyl;
  logic signed [11:0] pend_ff, nxt_pend;
  logic [31:0] tmr_ff, nxt_tmr;
  logic [31:0] gap_ff, rdy_cnt_ff, rev_cnt_ff, off_cnt_ff;
  logic        step_prev_ff, wd_prev_ff, fast_ff, ready_ff, seek_done_ff;
  logic        recal_pend_ff, por_recal_ff, fault_ff;
  logic [5:0]  cause_ff;
  logic        nxt_act_step, nxt_act_out, set_done, recal_go;

  assign axi_rsp = '{awready: awready_ff, wready: wready_ff, bvalid: bvalid_ff,
                     bresp: bresp_ff, arready: arready_ff, rvalid: rvalid_ff,
                     rdata: rdata_ff, rresp: rresp_ff};

  // write channel: address and data taken in either order
  wire        aw_hs    = axi_req.awvalid & awready_ff;
  wire        w_hs     = axi_req.wvalid & wready_ff;
  wire        aw_have  = aw_got_ff | aw_hs;
  wire        w_have   = w_got_ff | w_hs;
  wire        wr_do    = aw_have & w_have;
  wire [7:0]  wa       = aw_hs ? axi_req.awaddr : awaddr_ff;
  wire [31:0] wd       = w_hs ? axi_req.wdata : wdata_ff;
  wire [3:0]  ws       = w_hs ? axi_req.wstrb : wstrb_ff;
  wire        wr_ctrl  = wr_do & hit(wa, `DD_OFF_CTRL) & ws[0];
  wire        wr_map   = hit(wa, `DD_OFF_CTRL) | hit(wa, `DD_OFF_STAT) |
                         hit(wa, `DD_OFF_CYL) | hit(wa, `DD_OFF_CAUSE);
  wire        nxt_awg  = aw_have & ~wr_do;
  wire        nxt_wg   = w_have & ~wr_do;
  wire        nxt_bv   = wr_do | (bvalid_ff & ~axi_req.bready);
  wire        ar_hs    = axi_req.arvalid & arready_ff;
  wire        nxt_rv   = ar_hs | (rvalid_ff & ~axi_req.rready);
  wire        recal_sw = wr_ctrl & wd[`DD_CTRL_RECAL];

  wire [31:0] stat_word = {22'h0, state_ff == SK_RECAL, fast_ff, head_ff, cyl_ff == 10'h0,
                           fault_ff, seek_done_ff, ready_ff, sel, wr_en_ff};
  wire [7:0]  ra = axi_req.araddr;
  wire [31:0] rd_word = hit(ra, `DD_OFF_CTRL)  ? {30'h0, ctrl_immed_ff, 1'b0} :
                        hit(ra, `DD_OFF_STAT)  ? stat_word :
                        hit(ra, `DD_OFF_CYL)   ? {22'h0, cyl_ff} :
                        hit(ra, `DD_OFF_CAUSE) ? {26'h0, cause_ff} : 32'h0;
  wire rd_map = hit(ra, `DD_OFF_CTRL) | hit(ra, `DD_OFF_STAT) |
                hit(ra, `DD_OFF_CYL) | hit(ra, `DD_OFF_CAUSE);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      awready_ff    <= 1'b1;
      wready_ff     <= 1'b1;
      bvalid_ff     <= 1'b0;
      bresp_ff      <= `DD_RESP_OKAY;
      arready_ff    <= 1'b1;
      rvalid_ff     <= 1'b0;
      rresp_ff      <= `DD_RESP_OKAY;
      rdata_ff      <= 32'h0;
      awaddr_ff     <= 8'h0;
      wdata_ff      <= 32'h0;
      wstrb_ff      <= 4'h0;
      ctrl_immed_ff <= 1'b0;
    end else begin
      aw_got_ff  <= nxt_awg;
      w_got_ff   <= nxt_wg;
      awready_ff <= ~nxt_awg & ~nxt_bv;
      wready_ff  <= ~nxt_wg & ~nxt_bv;
      bvalid_ff  <= nxt_bv;
      arready_ff <= ~nxt_rv;
      rvalid_ff  <= nxt_rv;
      if (aw_hs) awaddr_ff <= axi_req.awaddr;
      if (w_hs) begin
        wdata_ff <= axi_req.wdata;
        wstrb_ff <= axi_req.wstrb;
      end
      if (wr_do) bresp_ff <= wr_map ? `DD_RESP_OKAY : `DD_RESP_DECERR;
      if (ar_hs) begin
        rdata_ff <= rd_word;
        rresp_ff <= rd_map ? `DD_RESP_OKAY : `DD_RESP_DECERR;
      end
      if (wr_ctrl) ctrl_immed_ff <= wd[`DD_CTRL_IMMED];
    end
  end

  // selection: switch bank not one-hot selects nothing
  wire sel        = $onehot(unit_switch) & |(~unit_select_n & unit_switch);
  wire gate_on    = sel & ~wr_gate_n;
  wire step_lead  = sel & ready_ff & step_prev_ff & ~step_n;
  wire dir_out    = step_dir_in_n;
  wire wpair      = flux_write_pair_p & ~flux_write_pair_n;
  wire [9:0] top  = 10'(MAX_CYL - 1);
  wire trk0_abn   = por_recal_ff & (state_ff == SK_RECAL) & (trk0_sense != (cyl_ff == 10'h0));
  wire [5:0] cause = {trk0_abn, ~spindle_ok, ~supply_ok, head_sel_fault,
                      wr_en_ff & ~wr_current_sense, wr_current_sense & ~wr_en_ff};
  wire fault_clr  = ~(|cause) & (wr_gate_n | ~sel);
  // supply dips and the power-up wait both mask the gate
  wire nxt_wr_en  = gate_on & ready_ff & supply_ok & ~fault_ff;
  wire idx_act    = rev_cnt_ff < IDX_CYC;

  // seek engine: single moves, buffered trains and recalibration
  always_comb begin
    nxt_state    = state_ff;
    nxt_cyl      = cyl_ff;
    nxt_tmr      = (tmr_ff != 32'h0) ? tmr_ff - 32'h1 : 32'h0;
    nxt_act_step = 1'b0;
    nxt_act_out  = act_out_ff;
    nxt_pend     = pend_ff;
    set_done     = 1'b0;
    recal_go     = 1'b0;
    if (step_lead)
      nxt_pend = dir_out ? pend_ff - 12'sd1 : pend_ff + 12'sd1;
    case (state_ff)
      SK_IDLE: begin
        if (recal_pend_ff & ready_ff) begin
          nxt_state = SK_RECAL;
          recal_go  = 1'b1;
        end else if (pend_ff != 12'sd0 && ready_ff &&
                     (!fast_ff || ctrl_immed_ff || gap_ff >= BUF_CYC)) begin
          nxt_state = SK_MOVE;
          nxt_tmr   = 32'h0;
        end
      end
      SK_MOVE: begin
        if (tmr_ff == 32'h0) begin
          if (pend_ff == 12'sd0) begin
            nxt_state = SK_SETTLE;
            nxt_tmr   = SETTLE_CYC;
          end else if (pend_ff > 12'sd0 && cyl_ff == top) begin
            nxt_state = SK_RECAL;
            recal_go  = 1'b1;
          end else if (pend_ff < 12'sd0 && cyl_ff == 10'h0) begin
            nxt_pend  = nxt_pend + 12'sd1;
          end else begin
            nxt_act_step = 1'b1;
            nxt_act_out  = pend_ff < 12'sd0;
            nxt_cyl      = (pend_ff < 12'sd0) ? cyl_ff - 10'h1 : cyl_ff + 10'h1;
            nxt_pend     = (pend_ff < 12'sd0) ? nxt_pend + 12'sd1 : nxt_pend - 12'sd1;
            nxt_tmr      = STEP_CYC - 1;
          end
        end
      end
      SK_SETTLE: begin
        // wait out the drop window so seek complete really goes inactive
        if (tmr_ff == 32'h0 && off_cnt_ff == 32'h0) begin
          nxt_state = SK_IDLE;
          set_done  = (pend_ff == 12'sd0);
        end
      end
      SK_RECAL: begin
        nxt_pend = 12'sd0;
        if (tmr_ff == 32'h0) begin
          if (cyl_ff == 10'h0) begin
            nxt_state = SK_SETTLE;
            nxt_tmr   = SETTLE_CYC;
          end else begin
            nxt_act_step = 1'b1;
            nxt_act_out  = 1'b1;
            nxt_cyl      = cyl_ff - 10'h1;
            nxt_tmr      = STEP_CYC - 1;
          end
        end
      end
      default: nxt_state = SK_IDLE;
    endcase
    if (recal_go)
      nxt_pend = 12'sd0;
    if (!ready_ff) begin
      nxt_state    = SK_IDLE;
      nxt_act_step = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff      <= SK_IDLE;
      cyl_ff        <= 10'h0;
      pend_ff       <= 12'sd0;
      tmr_ff        <= 32'h0;
      act_step_ff   <= 1'b0;
      act_out_ff    <= 1'b0;
      step_prev_ff  <= 1'b1;
      wd_prev_ff    <= 1'b0;
      gap_ff        <= T2T_CYC;
      fast_ff       <= 1'b0;
      off_cnt_ff    <= 32'h0;
      seek_done_ff  <= 1'b0;
      rdy_cnt_ff    <= 32'h0;
      ready_ff      <= 1'b0;
      recal_pend_ff <= 1'b1;
      por_recal_ff  <= 1'b1;
      fault_ff      <= 1'b0;
      cause_ff      <= 6'h0;
      rev_cnt_ff    <= 32'h0;
    end else begin
      state_ff     <= nxt_state;
      cyl_ff       <= nxt_cyl;
      pend_ff      <= nxt_pend;
      tmr_ff       <= nxt_tmr;
      act_step_ff  <= nxt_act_step;
      act_out_ff   <= nxt_act_out;
      step_prev_ff <= step_n;
      wd_prev_ff   <= wpair;
      // spacing of pulses picks single moves or a buffered train
      if (step_lead) begin
        gap_ff  <= 32'h0;
        fast_ff <= gap_ff < T2T_CYC;
      end else if (gap_ff < T2T_CYC) begin
        gap_ff <= gap_ff + 32'h1;
      end
      if (step_lead)
        off_cnt_ff <= SOFF_CYC;
      else if (off_cnt_ff != 32'h0)
        off_cnt_ff <= off_cnt_ff - 32'h1;
      if (recal_go || !ready_ff || off_cnt_ff == 32'h1)
        seek_done_ff <= 1'b0;
      else if (set_done)
        seek_done_ff <= 1'b1;
      // a supply dip restarts the power-up wait
      if (!supply_ok) begin
        rdy_cnt_ff <= 32'h0;
        ready_ff   <= 1'b0;
      end else if (rdy_cnt_ff >= READY_CYC - 1) begin
        ready_ff <= 1'b1;
      end else begin
        rdy_cnt_ff <= rdy_cnt_ff + 32'h1;
      end
      // set wins over clear
      if (|cause) begin
        fault_ff <= 1'b1;
        cause_ff <= cause_ff | cause;
      end else if (fault_clr) begin
        fault_ff <= 1'b0;
        cause_ff <= 6'h0;
      end
      if (!supply_ok || recal_sw || (|cause && !fault_ff))
        recal_pend_ff <= 1'b1;
      else if (recal_go)
        recal_pend_ff <= 1'b0;
      if (!supply_ok)
        por_recal_ff <= 1'b1;
      else if (state_ff == SK_SETTLE && !recal_pend_ff)
        por_recal_ff <= 1'b0;
      rev_cnt_ff <= (rev_cnt_ff >= REV_CYC - 1) ? 32'h0 : rev_cnt_ff + 32'h1;
    end
  end

  // pins toward the controller; status reads inactive while deselected
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      seek_done_n_ff      <= 1'b1;
      at_outer_track_n_ff <= 1'b1;
      write_fault_n_ff    <= 1'b1;
      index_n_ff          <= 1'b1;
      ready_n_ff          <= 1'b1;
      flux_read_pair_p_ff <= 1'b0;
      flux_read_pair_n_ff <= 1'b1;
      led_ff              <= 1'b0;
      head_ff             <= 2'h0;
      wr_en_ff            <= 1'b0;
      head_flux_ff        <= 1'b0;
    end else begin
      seek_done_n_ff      <= ~(sel & seek_done_ff);
      at_outer_track_n_ff <= ~(sel & cyl_ff == 10'h0);
      write_fault_n_ff    <= ~(sel & fault_ff);
      index_n_ff          <= ~(sel & idx_act);
      ready_n_ff          <= ~(sel & ready_ff);
      flux_read_pair_p_ff <= sel & wr_gate_n & ready_ff & medium_flux;
      flux_read_pair_n_ff <= ~(sel & wr_gate_n & ready_ff & medium_flux);
      led_ff              <= sel;
      if (sel)
        head_ff <= ~{head_sel_bit1_n, head_sel_bit0_n};
      wr_en_ff            <= nxt_wr_en;
      // a parked write pair never reads as a rising edge
      head_flux_ff        <= wr_en_ff & wpair & ~wd_prev_ff;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_step_lead;
    step_lead;
  endsequence
  sequence s_done_drop;
    ##1 (off_cnt_ff == SOFF_CYC);
  endsequence

  property p_gate_write;
    wr_en_ff |-> $past(gate_on) && !$past(fault_ff) && $past(ready_ff);
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("write without gate");
  property p_head_code;
    $past(sel) |-> head_ff == ~{$past(head_sel_bit1_n), $past(head_sel_bit0_n)};
  endproperty
  a_head_code: assert property (p_head_code) else $error("head code wrong");
  property p_step_out;
    act_step_ff && act_out_ff |-> cyl_ff == $past(cyl_ff) - 10'h1;
  endproperty
  a_step_out: assert property (p_step_out) else $error("outward step wrong");
  property p_seek_off;
    s_step_lead |-> s_done_drop;
  endproperty
  a_seek_off: assert property (p_seek_off) else $error("seek complete held");
  property p_seek_low;
    (off_cnt_ff == 32'h1) |=> !seek_done_ff;
  endproperty
  a_seek_low: assert property (p_seek_low) else $error("seek complete not dropped");
  property p_trk0;
    !at_outer_track_n_ff |-> $past(cyl_ff) == 10'h0;
  endproperty
  a_trk0: assert property (p_trk0) else $error("track zero off track");
  property p_fault_inhibit;
    !write_fault_n_ff |-> !wr_en_ff;
  endproperty
  a_fault_inhibit: assert property (p_fault_inhibit) else $error("write in fault");
  property p_index;
    !index_n_ff |-> $past(rev_cnt_ff) < IDX_CYC;
  endproperty
  a_index: assert property (p_index) else $error("index too long");
  property p_ready;
    !ready_ff |=> !act_step_ff && !wr_en_ff;
  endproperty
  a_ready: assert property (p_ready) else $error("activity while not ready");
  property p_read_pair;
    flux_read_pair_p_ff |-> !flux_read_pair_n_ff && $past(medium_flux) && $past(wr_gate_n);
  endproperty
  a_read_pair: assert property (p_read_pair) else $error("read pair wrong");
  property p_write_flux;
    head_flux_ff |-> $past(wr_en_ff) && $past(wpair) && !$past(wd_prev_ff);
  endproperty
  a_write_flux: assert property (p_write_flux) else $error("flux without gate");
  property p_desel;
    !sel |=> index_n_ff && seek_done_n_ff && write_fault_n_ff && ready_n_ff && !led_ff;
  endproperty
  a_desel: assert property (p_desel) else $error("status while deselected");
endmodule // dd_drive
`default_nettype wire

//--- dd_host_model.sv
// controller-side model driving the drive's control and write-data pins
`timescale 1ns/100ps
`default_nettype none
module dd_host_model (
  input  wire logic       sys_clk,
  output logic            wr_gate_n,
  output logic            head_sel_bit0_n,
  output logic            head_sel_bit1_n,
  output logic            step_n,
  output logic            step_dir_in_n,
  output logic [3:0]      unit_select_n,
  output logic            flux_write_pair_p,
  output logic            flux_write_pair_n
);
  // idle: nothing selected, write pair parked negative
  initial begin
    {wr_gate_n, head_sel_bit1_n, head_sel_bit0_n, step_n, step_dir_in_n} = 5'h1F;
    unit_select_n = 4'hF;
    {flux_write_pair_p, flux_write_pair_n} = 2'h1;
  end
  task automatic pick(input logic [3:0] sel_n, input logic [1:0] hd);
    @(posedge sys_clk);
    unit_select_n <= sel_n;
    {head_sel_bit1_n, head_sel_bit0_n} <= ~hd;
  endtask
  // direction settles well ahead and outlives the pulse
  task automatic step(input logic out);
    @(posedge sys_clk);
    step_dir_in_n <= out;
    repeat (13) @(posedge sys_clk);
    step_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    step_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic gate(input logic on);
    @(posedge sys_clk);
    wr_gate_n <= ~on;
  endtask
  // pair leaves its parked state only while gated
  task automatic wflux;
    @(posedge sys_clk);
    if (!wr_gate_n) {flux_write_pair_p, flux_write_pair_n} <= 2'h2;
    @(posedge sys_clk);
    {flux_write_pair_p, flux_write_pair_n} <= 2'h1;
    @(posedge sys_clk);
  endtask
endmodule // dd_host_model
`default_nettype wire

//--- dd_pkg.sv
// types shared by the drive interface
package dd_pkg;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } dd_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dd_axi_rsp_t;
  typedef enum {SK_IDLE, SK_MOVE, SK_SETTLE, SK_RECAL} dd_seek_t;
endpackage

//--- tb_disk_drive_interface.sv
// self-checking bench for the drive interface with a controller model
`include "dd_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
`define WAIT_UNTIL(c, n) for (int k = 0; k < (n) && !(c); k++) @(posedge sys_clk);
module tb_disk_drive_interface;
  import dd_pkg::*;
  localparam int READY = 200, T2T = 400, BUF = 100, REV = 500, IDX = 45, SETTLE = 50;
  logic        sys_clk, srst, head_sel_fault, medium_flux, wr_current_sense, trk0_sense;
  logic        wr_gate_n, head_sel_bit0_n, head_sel_bit1_n, step_n, step_dir_in_n;
  logic        flux_write_pair_p, flux_write_pair_n, seek_done_n_ff, at_outer_track_n_ff;
  logic        write_fault_n_ff, index_n_ff, ready_n_ff, flux_read_pair_p_ff;
  logic        flux_read_pair_n_ff, led_ff, wr_en_ff, head_flux_ff, act_step_ff, act_out_ff;
  logic [1:0]  head_ff, resp;
  logic [3:0]  unit_select_n, unit_switch;
  logic        supply_ok, spindle_ok;
  logic [31:0] rd;
  dd_axi_req_t axi_req;
  dd_axi_rsp_t axi_rsp;
  int          n_fail = 0, checked = 0, cyl = 0, steps = 0, wfl = 0, rfl = 0;
  // write current follows the driver; sensor follows the rebuilt position
  assign wr_current_sense = wr_en_ff;
  assign trk0_sense = (cyl == 0);
  dd_drive #(.READY_CYC(READY), .T2T_CYC(T2T), .BUF_CYC(BUF), .REV_CYC(REV),
    .IDX_CYC(IDX), .SETTLE_CYC(SETTLE)) dut (
    .sys_clk, .srst, .axi_req, .axi_rsp, .wr_gate_n, .head_sel_bit0_n, .head_sel_bit1_n,
    .step_n, .step_dir_in_n, .unit_select_n, .unit_switch, .flux_write_pair_p,
    .flux_write_pair_n, .medium_flux, .wr_current_sense, .head_sel_fault, .supply_ok,
    .spindle_ok, .trk0_sense, .seek_done_n_ff, .at_outer_track_n_ff, .write_fault_n_ff,
    .index_n_ff, .ready_n_ff, .flux_read_pair_p_ff, .flux_read_pair_n_ff, .led_ff, .head_ff,
    .wr_en_ff, .head_flux_ff, .act_step_ff, .act_out_ff);
  dd_host_model host (.sys_clk, .wr_gate_n, .head_sel_bit0_n, .head_sel_bit1_n, .step_n,
    .step_dir_in_n, .unit_select_n, .flux_write_pair_p, .flux_write_pair_n);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // position and pulse counts rebuilt from what the drive does
  always @(posedge sys_clk) begin
    if (act_step_ff === 1'b1) begin
      cyl   <= act_out_ff ? cyl - 1 : cyl + 1;
      steps <= steps + 1;
    end
    if (head_flux_ff === 1'b1) wfl <= wfl + 1;
    if ({flux_read_pair_p_ff, flux_read_pair_n_ff} === 2'b10) rfl <= rfl + 1;
  end
  task automatic give_verdict;
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do @(posedge sys_clk); while (axi_rsp.arready !== 1'b1);
    axi_req.arvalid <= 1'b0;
    do @(posedge sys_clk); while (axi_rsp.rvalid !== 1'b1);
    d = axi_rsp.rdata;
    r = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw;
    {pa, pw} = 2'b11;
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    {axi_req.awvalid, axi_req.wvalid, axi_req.bready} <= 3'b111;
    while (pa || pw) begin
      @(posedge sys_clk);
      if (pa && axi_rsp.awready === 1'b1) begin
        pa = 1'b0;
        axi_req.awvalid <= 1'b0;
      end
      if (pw && axi_rsp.wready === 1'b1) begin
        pw = 1'b0;
        axi_req.wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (axi_rsp.bvalid !== 1'b1);
    r = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask
  task automatic pulse_medium;
    medium_flux <= 1'b1;
    @(posedge sys_clk);
    medium_flux <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  // seek complete must drop, then return once the heads settle
  task automatic settle;
    `WAIT_UNTIL(seek_done_n_ff === 1'b1, 1600)
    `CHK(seek_done_n_ff, 1'b1)
    `WAIT_UNTIL(seek_done_n_ff === 1'b0, 4000)
    `CHK(seek_done_n_ff, 1'b0)
  endtask
  // a step while not ready is lost
  task automatic t_power;
    `CHK({ready_n_ff, seek_done_n_ff}, 2'b11)
    host.pick(4'hE, 2'd0);
    host.step(1'b0);
    `WAIT_UNTIL(ready_n_ff === 1'b0, 2 * READY)
    `CHK(steps, 0)
    `WAIT_UNTIL(seek_done_n_ff === 1'b0, 4 * SETTLE)
    `CHK({seek_done_n_ff, at_outer_track_n_ff, led_ff}, 3'b001)
  endtask
  task automatic t_heads;
    for (int h = 0; h < 4; h++) begin
      host.pick(4'hE, 2'(h));
      repeat (3) @(posedge sys_clk);
      `CHK(head_ff, 2'(h))
    end
    host.pick(4'hD, 2'd1);
    repeat (3) @(posedge sys_clk);
    `CHK({led_ff, ready_n_ff, seek_done_n_ff, at_outer_track_n_ff}, 4'h7)
    `CHK({index_n_ff, write_fault_n_ff, head_ff}, 4'hF)
    host.pick(4'hE, 2'd0);
    unit_switch <= 4'h3;
    repeat (3) @(posedge sys_clk);
    `CHK({led_ff, ready_n_ff}, 2'b01)
    unit_switch <= 4'h1;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic t_regs;
    axi_rd(`DD_OFF_STAT, rd, resp);
    `CHK(rd[3:1], 3'b111)
    axi_rd(8'h40, rd, resp);
    `CHK({resp, rd}, {`DD_RESP_DECERR, 32'h0})
    axi_wr(8'h40, 32'h1, resp);
    `CHK(resp, `DD_RESP_DECERR)
    axi_wr(`DD_OFF_CTRL, 32'h1, resp);
    `CHK(resp, `DD_RESP_OKAY)
    settle();
  endtask
  task automatic t_move(input logic out, input int exp_cyl);
    host.step(out);
    settle();
    `CHK(cyl, exp_cyl)
    `CHK(at_outer_track_n_ff, exp_cyl != 0)
  endtask
  // pulses well inside the buffered window still all land
  task automatic t_train;
    for (int i = 0; i < 3; i++) host.step(1'b0);
    settle();
    `CHK(cyl, 4)
  endtask
  task automatic t_write;
    int w0, r0;
    host.gate(1'b1);
    `WAIT_UNTIL(wr_en_ff === 1'b1, 8)
    w0 = wfl;
    r0 = rfl;
    host.wflux();
    host.wflux();
    pulse_medium();
    `CHK(wfl - w0, 2)
    `CHK(rfl - r0, 0)
    head_sel_fault <= 1'b1;
    `WAIT_UNTIL(write_fault_n_ff === 1'b0, 8)
    head_sel_fault <= 1'b0;
    w0 = wfl;
    host.wflux();
    repeat (4) @(posedge sys_clk);
    `CHK({wfl - w0, wr_en_ff, write_fault_n_ff}, {32'd0, 2'b00})
    host.gate(1'b0);
    `WAIT_UNTIL(write_fault_n_ff === 1'b1, 8)
    `CHK(write_fault_n_ff, 1'b1)
    settle();
    `CHK(cyl, 0)
  endtask
  task automatic t_read;
    int r0;
    r0 = rfl;
    pulse_medium();
    `CHK(rfl - r0, 1)
    `CHK({flux_read_pair_p_ff, flux_read_pair_n_ff}, 2'b01)
  endtask
  task automatic t_index;
    int n;
    `WAIT_UNTIL(index_n_ff === 1'b1, REV)
    `WAIT_UNTIL(index_n_ff === 1'b0, REV)
    for (n = 0; n < REV && index_n_ff === 1'b0; n++) @(posedge sys_clk);
    `CHK(n, IDX)
    for (n = IDX; n < 2 * REV && index_n_ff === 1'b1; n++) @(posedge sys_clk);
    `CHK(n, REV)
  endtask
  initial begin
    axi_req = '0;
    {srst, head_sel_fault, medium_flux} = 3'b100;
    {unit_switch, supply_ok, spindle_ok} = 6'h07;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_power();
    t_heads();
    t_regs();
    t_move(1'b0, 1);
    t_move(1'b1, 0);
    t_move(1'b0, 1);
    t_train();
    t_write();
    t_read();
    t_index();
    give_verdict();
  end
  // cut a hang well past the expected run length
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_fail++;
    give_verdict();
  end
endmodule // tb_disk_drive_interface
`default_nettype wire
